// ==== core/mthc_regs.vh ====
// register indices, field positions, reset values and timing figures
`ifndef MTHC_REGS_VH
`define MTHC_REGS_VH
// word indices; byte address is four times the index
`define MTHC_IDX_CTRL 5'h00
`define MTHC_IDX_INTERVAL 5'h01
`define MTHC_IDX_EXPOSURE 5'h02
`define MTHC_IDX_P1 5'h03
`define MTHC_IDX_P2 5'h04
`define MTHC_IDX_HYST 5'h05
`define MTHC_IDX_FOV_L 5'h06
`define MTHC_IDX_FOV_R 5'h07
`define MTHC_IDX_TILT 5'h08
`define MTHC_IDX_ANGLE 5'h09
`define MTHC_IDX_DIST 5'h0A
`define MTHC_IDX_STATUS 5'h0B
`define MTHC_IDX_AVG 5'h0C
`define MTHC_IDX_MIN 5'h0D
`define MTHC_IDX_MAX 5'h0E
`define MTHC_IDX_SPAN 5'h0F
`define MTHC_IDX_SIGMA 5'h10
`define MTHC_IDX_COUNT 5'h11
// control fields
`define MTHC_TRIG_CONT 2'h0
`define MTHC_TRIG_INTERVAL 2'h1
`define MTHC_TRIG_SINGLE 2'h2
`define MTHC_CTRL_HOLD_EN 2
`define MTHC_CTRL_WINDOW 3
`define MTHC_CTRL_ACT_LOW 4
`define MTHC_TILT_ON 0
`define MTHC_TILT_RESET 1
// quality codes
`define MTHC_Q_ABSENT 2'h0
`define MTHC_Q_WEAK 2'h1
`define MTHC_Q_VALID 2'h2
// reset values and the weak quality point threshold
`define MTHC_CTRL_RST 8'h04
`define MTHC_INTERVAL_RST 16'h000A
`define MTHC_EXPOSURE_RST 16'h0100
`define MTHC_FOV_L_MAX 16'h8000
`define MTHC_FOV_R_MAX 16'h7FFF
`define MTHC_DIST_END 16'h4000
`define MTHC_WEAK_MIN 12'h010
// timing
`define MTHC_CLK_MHZ 200
`define MTHC_RELEASE_NS 5000
`endif

// ==== core/mthc_top.v ====
// measurement sequencing, hold/trigger handling and result evaluation
//
// Overview of operation
// - continuous mode measures back to back
// - interval mode starts cycles every N ms
// - wired hold input gates continuous and interval runs when high
// - unwired hold input lets modes run freely
// - single shot measures once per falling edge
// - single shot results held until next edge
// - single shot rate at most half continuous
// - hold postpones measurement, laser power reduced
// - hold sampled right before each laser launch
// - running cycle finishes before hold is entered
// - switch and alarm outputs frozen while in hold state
// - first cycle after release 5 us longer
// - longer exposure lengthens measurement repeat time
// - average, minimum, maximum and span heights
// - dispersion is deviation of in-view points
// - quality is valid, weak or absent
// - switching output status active or inactive
// - switch points and view limits act immediately
// - tilted reference ignores points below surface
// - enabling tilted reference restores full view
// - tilt reset zeroes angle, distance to end
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`include "mthc_regs.vh"
`default_nettype none
module mthc_top #(
    parameter CYC_PER_MS = `MTHC_CLK_MHZ * 1000,
    parameter CNT_W = 12
) (
    // clock and reset
    input wire sys_clk_i,
    input wire nrst_i,
    // avalon-mm slave
    input wire [4:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // hold / trigger pin
    input wire sync_in_i,
    // profile points from the optical front end
    input wire pt_valid_i,
    input wire [15:0] pt_x_i,
    input wire [15:0] pt_z_i,
    input wire pt_last_i,
    // sensor outputs
    output reg meas_start_o,
    output reg laser_low_o,
    output reg switch_o,
    output reg alarm_o
);

localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_HOLD = 4'h1;
localparam [3:0] ST_REL = 4'h2;
localparam [3:0] ST_EXPO = 4'h3;
localparam [3:0] ST_ACQ = 4'h4;
localparam [3:0] ST_DIV = 4'h5;
localparam [3:0] ST_SQRT = 4'h6;
localparam [3:0] ST_PUB = 4'h7;
localparam [3:0] ST_GAP = 4'h8;

localparam integer MS_LAST_I = CYC_PER_MS - 1;
localparam [23:0] MS_LAST = MS_LAST_I[23:0];
localparam integer REL_I =
    (`MTHC_RELEASE_NS * `MTHC_CLK_MHZ + 999) / 1000;
localparam integer REL_LAST_I = REL_I - 1;
localparam [23:0] REL_LAST = REL_LAST_I[23:0];

// one restoring division step on a shifting dividend
function [CNT_W+47:0] div_step;
    input [CNT_W-1:0] rem;
    input [47:0] dvd;
    input [CNT_W-1:0] d;
    reg [CNT_W:0] t;
    begin
        t = {rem, dvd[47]};
        if (t >= {1'b0, d}) begin
            t = t - {1'b0, d};
            div_step = {t[CNT_W-1:0], dvd[46:0], 1'b1};
        end else begin
            div_step = {t[CNT_W-1:0], dvd[46:0], 1'b0};
        end
    end
endfunction

// reset release
reg rst_s1_reg;
reg rst_n_reg;
always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        rst_s1_reg <= 1'b0;
        rst_n_reg <= 1'b0;
    end else begin
        rst_s1_reg <= 1'b1;
        rst_n_reg <= rst_s1_reg;
    end
end

// pin synchroniser, presets high so a high pin keeps us in hold
reg [2:0] sync_reg;
reg hold_lvl_reg;
reg hold_prev_reg;
always @(posedge sys_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
        sync_reg <= 3'h7;
        hold_lvl_reg <= 1'b1;
        hold_prev_reg <= 1'b1;
    end else begin
        sync_reg <= {sync_reg[1:0], sync_in_i};
        if (sync_reg[1] == sync_reg[2])
            hold_lvl_reg <= sync_reg[2];
        hold_prev_reg <= hold_lvl_reg;
    end
end
wire trig_fall = hold_prev_reg & ~hold_lvl_reg;

// configuration registers
reg [7:0] ctrl_reg;
reg [15:0] interval_reg, expo_reg, p1_reg, p2_reg, hyst_reg;
reg [15:0] fov_l_reg, fov_r_reg, angle_reg, dist_reg;
reg tilt_on_reg;
wire [1:0] trig_mode = ctrl_reg[1:0];
wire hold_en = ctrl_reg[`MTHC_CTRL_HOLD_EN];
wire wr_go = avs_write_i & avs_waitrequest_o;
wire rd_go = avs_read_i & avs_waitrequest_o;

always @(posedge sys_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
        ctrl_reg <= `MTHC_CTRL_RST;
        interval_reg <= `MTHC_INTERVAL_RST;
        expo_reg <= `MTHC_EXPOSURE_RST;
        p1_reg <= 16'h0000;
        p2_reg <= 16'h0000;
        hyst_reg <= 16'h0000;
        fov_l_reg <= `MTHC_FOV_L_MAX;
        fov_r_reg <= `MTHC_FOV_R_MAX;
        tilt_on_reg <= 1'b0;
        angle_reg <= 16'h0000;
        dist_reg <= `MTHC_DIST_END;
    end else if (wr_go) begin
        case (avs_address_i)
            `MTHC_IDX_CTRL: ctrl_reg <= avs_writedata_i[7:0];
            `MTHC_IDX_INTERVAL: interval_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_EXPOSURE: expo_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_P1: p1_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_P2: p2_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_HYST: hyst_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_FOV_L: fov_l_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_FOV_R: fov_r_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_ANGLE: angle_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_DIST: dist_reg <= avs_writedata_i[15:0];
            `MTHC_IDX_TILT: begin
                if (avs_writedata_i[`MTHC_TILT_RESET]) begin
                    tilt_on_reg <= 1'b0;
                    angle_reg <= 16'h0000;
                    dist_reg <= `MTHC_DIST_END;
                    fov_l_reg <= `MTHC_FOV_L_MAX;
                    fov_r_reg <= `MTHC_FOV_R_MAX;
                end else begin
                    if (avs_writedata_i[`MTHC_TILT_ON] && !tilt_on_reg) begin
                        fov_l_reg <= `MTHC_FOV_L_MAX;
                        fov_r_reg <= `MTHC_FOV_R_MAX;
                    end
                    tilt_on_reg <= avs_writedata_i[`MTHC_TILT_ON];
                end
            end
            default: ;
        endcase
    end
end

// interval time base
reg [23:0] ms_cnt_reg;
reg [15:0] iv_cnt_reg;
reg tick_pend_reg;
reg trig_pend_reg;
reg [3:0] state_reg;
reg [23:0] tmr_reg;
reg [CNT_W-1:0] acc_n_reg;
wire launch;

always @(posedge sys_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
        ms_cnt_reg <= 24'h00_0000;
        iv_cnt_reg <= 16'h0000;
        tick_pend_reg <= 1'b0;
        trig_pend_reg <= 1'b0;
    end else begin
        if (trig_mode != `MTHC_TRIG_INTERVAL) begin
            ms_cnt_reg <= 24'h00_0000;
            iv_cnt_reg <= 16'h0000;
            tick_pend_reg <= 1'b0;
        end else if (ms_cnt_reg == MS_LAST) begin
            ms_cnt_reg <= 24'h00_0000;
            if (iv_cnt_reg + 16'h0001 >= interval_reg) begin
                iv_cnt_reg <= 16'h0000;
                tick_pend_reg <= 1'b1;
            end else begin
                iv_cnt_reg <= iv_cnt_reg + 16'h0001;
                if (launch)
                    tick_pend_reg <= 1'b0;
            end
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 24'h00_0001;
            if (launch)
                tick_pend_reg <= 1'b0;
        end
        if (trig_mode != `MTHC_TRIG_SINGLE)
            trig_pend_reg <= 1'b0;
        else if (trig_fall)
            trig_pend_reg <= 1'b1;
        else if (launch)
            trig_pend_reg <= 1'b0;
    end
end

// launch decision
// unwired pin never holds
wire hold_act = hold_en & hold_lvl_reg &
    (trig_mode != `MTHC_TRIG_SINGLE);
reg want;
always @* begin
    case (trig_mode)
        `MTHC_TRIG_CONT: want = 1'b1;
        `MTHC_TRIG_INTERVAL: want = tick_pend_reg;
        `MTHC_TRIG_SINGLE: want = trig_pend_reg;
        default: want = 1'b0;
    endcase
end
assign launch = ((state_reg == ST_IDLE) & want & ~hold_act) |
    ((state_reg == ST_REL) & (tmr_reg == REL_LAST) & ~hold_lvl_reg);

// profile point qualification
wire [15:0] h_pt = dist_reg - pt_z_i;
wire in_fov = ($signed(pt_x_i) >= $signed(fov_l_reg)) &&
    ($signed(pt_x_i) <= $signed(fov_r_reg));
wire below = tilt_on_reg & h_pt[15];
wire keep = pt_valid_i & in_fov & ~below & ~(&acc_n_reg);

// working registers
reg [23:0] len_reg;
reg [31:0] acc_sum_reg;
reg [47:0] acc_sq_reg;
reg [15:0] acc_min_reg, acc_max_reg;
reg [47:0] dv_a_reg, dv_b_reg;
reg [CNT_W-1:0] rm_a_reg, rm_b_reg;
reg [5:0] step_reg;
reg [15:0] root_reg;
reg [31:0] var_reg;
reg sw_on_reg;
reg [15:0] avg_reg, min_reg, max_reg, span_reg, sigma_reg;
reg [CNT_W-1:0] n_reg;
reg [1:0] qual_reg;

wire [31:0] sq_pt = $signed(h_pt) * $signed(h_pt);
wire [31:0] sum_abs = acc_sum_reg[31] ? -acc_sum_reg : acc_sum_reg;
wire [CNT_W+47:0] nx_a = div_step(rm_a_reg, dv_a_reg, acc_n_reg);
wire [CNT_W+47:0] nx_b = div_step(rm_b_reg, dv_b_reg, acc_n_reg);
wire [15:0] mean_abs = dv_a_reg[15:0];
wire [31:0] mean_sq = mean_abs * mean_abs;
wire [15:0] trial = root_reg | (16'h0001 << step_reg[3:0]);
wire [31:0] trial_sq = trial * trial;
wire [15:0] r_avg = acc_sum_reg[31] ? -mean_abs : mean_abs;
wire [15:0] r_span = acc_max_reg - acc_min_reg;
wire [1:0] r_qual = (acc_n_reg == {CNT_W{1'b0}}) ? `MTHC_Q_ABSENT :
    (acc_n_reg < `MTHC_WEAK_MIN) ? `MTHC_Q_WEAK : `MTHC_Q_VALID;

// switch point evaluation on the selected result
reg [15:0] sel_v;
reg sw_next;
always @* begin
    case (ctrl_reg[7:5])
        3'h1: sel_v = acc_min_reg;
        3'h2: sel_v = acc_max_reg;
        3'h3: sel_v = r_span;
        3'h4: sel_v = root_reg;
        default: sel_v = r_avg;
    endcase
    if (ctrl_reg[`MTHC_CTRL_WINDOW])
        sw_next = ($signed(sel_v) <= $signed(p1_reg)) &&
            ($signed(sel_v) >= $signed(p2_reg));
    else if (sw_on_reg)
        sw_next = $signed(sel_v) > $signed(p1_reg - hyst_reg);
    else
        sw_next = $signed(sel_v) > $signed(p1_reg);
    if (r_qual == `MTHC_Q_ABSENT)
        sw_next = sw_on_reg;
end

// measurement sequencer
always @(posedge sys_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
        state_reg <= ST_IDLE;
        tmr_reg <= 24'h00_0000;
        len_reg <= 24'h00_0000;
        acc_sum_reg <= 32'h0000_0000;
        acc_sq_reg <= 48'h0000_0000_0000;
        acc_min_reg <= 16'h7FFF;
        acc_max_reg <= 16'h8000;
        acc_n_reg <= {CNT_W{1'b0}};
        dv_a_reg <= 48'h0000_0000_0000;
        dv_b_reg <= 48'h0000_0000_0000;
        rm_a_reg <= {CNT_W{1'b0}};
        rm_b_reg <= {CNT_W{1'b0}};
        step_reg <= 6'h00;
        root_reg <= 16'h0000;
        var_reg <= 32'h0000_0000;
        sw_on_reg <= 1'b0;
        avg_reg <= 16'h0000;
        min_reg <= 16'h0000;
        max_reg <= 16'h0000;
        span_reg <= 16'h0000;
        sigma_reg <= 16'h0000;
        n_reg <= {CNT_W{1'b0}};
        qual_reg <= `MTHC_Q_ABSENT;
        meas_start_o <= 1'b0;
        laser_low_o <= 1'b0;
        switch_o <= 1'b0;
        alarm_o <= 1'b1;
    end else begin
        meas_start_o <= launch;
        if (state_reg != ST_IDLE && state_reg != ST_HOLD &&
                state_reg != ST_REL && state_reg != ST_GAP)
            len_reg <= len_reg + 24'h00_0001;
        if (launch) begin
            state_reg <= ST_EXPO;
            tmr_reg <= {8'h00, expo_reg};
            len_reg <= 24'h00_0001;
            laser_low_o <= 1'b0;
            acc_sum_reg <= 32'h0000_0000;
            acc_sq_reg <= 48'h0000_0000_0000;
            acc_min_reg <= 16'h7FFF;
            acc_max_reg <= 16'h8000;
            acc_n_reg <= {CNT_W{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (hold_act) begin
                        state_reg <= ST_HOLD;
                        laser_low_o <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    laser_low_o <= 1'b1;
                    tmr_reg <= 24'h00_0000;
                    if (!hold_lvl_reg || !hold_en ||
                            trig_mode == `MTHC_TRIG_SINGLE)
                        state_reg <= ST_REL;
                end
                ST_REL: begin
                    if (hold_lvl_reg && hold_en) begin
                        state_reg <= ST_HOLD;
                    end else if (tmr_reg == REL_LAST) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        tmr_reg <= tmr_reg + 24'h00_0001;
                    end
                end
                ST_EXPO: begin
                    if (tmr_reg == 24'h00_0000)
                        state_reg <= ST_ACQ;
                    else
                        tmr_reg <= tmr_reg - 24'h00_0001;
                end
                ST_ACQ: begin
                    if (keep) begin
                        acc_sum_reg <= acc_sum_reg + {{16{h_pt[15]}}, h_pt};
                        acc_sq_reg <= acc_sq_reg + {16'h0000, sq_pt};
                        acc_n_reg <= acc_n_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                        if ($signed(h_pt) < $signed(acc_min_reg))
                            acc_min_reg <= h_pt;
                        if ($signed(h_pt) > $signed(acc_max_reg))
                            acc_max_reg <= h_pt;
                    end
                    if (pt_valid_i && pt_last_i) begin
                        state_reg <= ST_DIV;
                        rm_a_reg <= {CNT_W{1'b0}};
                        rm_b_reg <= {CNT_W{1'b0}};
                        step_reg <= 6'h00;
                    end
                end
                ST_DIV: begin
                    if (acc_n_reg == {CNT_W{1'b0}}) begin
                        state_reg <= ST_PUB;
                        root_reg <= 16'h0000;
                        dv_a_reg <= 48'h0000_0000_0000;
                    end else if (step_reg == 6'h00) begin
                        // load once the last point is summed
                        step_reg <= 6'h01;
                        dv_a_reg <= {16'h0000, sum_abs};
                        dv_b_reg <= acc_sq_reg;
                    end else if (step_reg == 6'h31) begin
                        state_reg <= ST_SQRT;
                        step_reg <= 6'h0F;
                        root_reg <= 16'h0000;
                        var_reg <= (dv_b_reg[31:0] > mean_sq) ?
                            dv_b_reg[31:0] - mean_sq : 32'h0000_0000;
                    end else begin
                        step_reg <= step_reg + 6'h01;
                        {rm_a_reg, dv_a_reg} <= nx_a;
                        {rm_b_reg, dv_b_reg} <= nx_b;
                    end
                end
                ST_SQRT: begin
                    if (trial_sq <= var_reg)
                        root_reg <= trial;
                    if (step_reg == 6'h00)
                        state_reg <= ST_PUB;
                    else
                        step_reg <= step_reg - 6'h01;
                end
                ST_PUB: begin
                    avg_reg <= r_avg;
                    min_reg <= acc_min_reg;
                    max_reg <= acc_max_reg;
                    span_reg <= r_span;
                    sigma_reg <= root_reg;
                    n_reg <= acc_n_reg;
                    qual_reg <= r_qual;
                    alarm_o <= (r_qual == `MTHC_Q_ABSENT);
                    sw_on_reg <= sw_next;
                    switch_o <= sw_next ^ ctrl_reg[`MTHC_CTRL_ACT_LOW];
                    tmr_reg <= len_reg;
                    state_reg <= (trig_mode == `MTHC_TRIG_SINGLE) ?
                        ST_GAP : ST_IDLE;
                end
                ST_GAP: begin
                    if (tmr_reg == 24'h00_0000)
                        state_reg <= ST_IDLE;
                    else
                        tmr_reg <= tmr_reg - 24'h00_0001;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
end

// register read-back and bus handshake
reg [31:0] rd_mux;
always @* begin
    case (avs_address_i)
        `MTHC_IDX_CTRL: rd_mux = {24'h00_0000, ctrl_reg};
        `MTHC_IDX_INTERVAL: rd_mux = {16'h0000, interval_reg};
        `MTHC_IDX_EXPOSURE: rd_mux = {16'h0000, expo_reg};
        `MTHC_IDX_P1: rd_mux = {16'h0000, p1_reg};
        `MTHC_IDX_P2: rd_mux = {16'h0000, p2_reg};
        `MTHC_IDX_HYST: rd_mux = {16'h0000, hyst_reg};
        `MTHC_IDX_FOV_L: rd_mux = {16'h0000, fov_l_reg};
        `MTHC_IDX_FOV_R: rd_mux = {16'h0000, fov_r_reg};
        `MTHC_IDX_TILT: rd_mux = {31'h0000_0000, tilt_on_reg};
        `MTHC_IDX_ANGLE: rd_mux = {16'h0000, angle_reg};
        `MTHC_IDX_DIST: rd_mux = {16'h0000, dist_reg};
        `MTHC_IDX_STATUS: rd_mux = {23'h00_0000, state_reg, hold_lvl_reg,
            laser_low_o, sw_on_reg, qual_reg};
        `MTHC_IDX_AVG: rd_mux = {{16{avg_reg[15]}}, avg_reg};
        `MTHC_IDX_MIN: rd_mux = {{16{min_reg[15]}}, min_reg};
        `MTHC_IDX_MAX: rd_mux = {{16{max_reg[15]}}, max_reg};
        `MTHC_IDX_SPAN: rd_mux = {16'h0000, span_reg};
        `MTHC_IDX_SIGMA: rd_mux = {16'h0000, sigma_reg};
        `MTHC_IDX_COUNT: rd_mux = {{(32-CNT_W){1'b0}}, n_reg};
        default: rd_mux = 32'h0000_0000;
    endcase
end

always @(posedge sys_clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
        avs_waitrequest_o <= 1'b1;
        avs_readdata_o <= 32'h0000_0000;
    end else begin
        avs_waitrequest_o <= ~(wr_go | rd_go);
        if (rd_go)
            avs_readdata_o <= rd_mux;
    end
end

endmodule // mthc_top
`default_nettype wire

// ==== testbench/mthc_top_monitor.sv ====
// port checker for the sequencing block
`default_nettype none
module mthc_top_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // bus
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // pins
    input wire logic sync_in_i,
    input wire logic meas_start_o,
    input wire logic laser_low_o,
    input wire logic switch_o,
    input wire logic alarm_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] low_cnt_reg;
    logic held_reg;
    // consecutive low cycles of the pin, and a hold seen since last launch
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_cnt_reg <= 11'h000;
            held_reg <= 1'b0;
        end else begin
            low_cnt_reg <= sync_in_i ? 11'h000
                : low_cnt_reg + {10'h000, ~&low_cnt_reg};
            held_reg <= laser_low_o | (held_reg & ~meas_start_o);
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_bus_answer: assert property ((avs_read_i || avs_write_i)
        && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");
    a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("acknowledge longer than one cycle");
    a_unmapped_zero: assert property (!avs_waitrequest_o && avs_read_i
        && avs_address_i > 5'h11 |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_start_spacing: assert property (
        meas_start_o |=> !meas_start_o [*8])
        else $error("launches too close");
    a_hold_quiet: assert property (laser_low_o |-> !meas_start_o)
        else $error("launch while laser reduced");
    a_hold_entry: assert property (
        $rose(laser_low_o) |-> !$past(meas_start_o))
        else $error("hold entered in a running cycle");
    a_hold_freeze: assert property (
        laser_low_o && $past(laser_low_o)
        |-> $stable(switch_o) && $stable(alarm_o))
        else $error("outputs moved during hold");
    a_release_wait: assert property (
        meas_start_o && held_reg |-> low_cnt_reg >= 11'h3E8)
        else $error("launch too soon after release");
endmodule // mthc_top_monitor
bind mthc_top mthc_top_monitor u_mthc_top_monitor (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .sync_in_i(sync_in_i), .meas_start_o(meas_start_o),
    .laser_low_o(laser_low_o), .switch_o(switch_o), .alarm_o(alarm_o));
`default_nettype wire

// ==== testbench/mthc_ctrl_model.sv ====
// superordinate control on the pin plus a profile point source
`default_nettype none
module mthc_ctrl_model (
    // clock
    input wire logic clk_i,
    // launch from the device
    input wire logic meas_start_i,
    // pin and point stream
    output logic sync_o,
    output logic pt_valid_o,
    output logic [15:0] pt_x_o,
    output logic [15:0] pt_z_o,
    output logic pt_last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'hFF;
    initial sync_o = 1'b1;
    // edges on clock, high or low time set by caller
    task drive(input logic lvl, input int cycles);
        @(posedge clk_i);
        sync_o <= lvl;
        repeat (cycles) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cnt <= meas_start_i ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
    end
    // sixteen points, heights 0,10,20,30 repeating, after exposure
    assign pt_valid_o = cnt >= 8'h0A && cnt < 8'h1A;
    assign pt_last_o = cnt == 8'h19;
    assign pt_x_o = pt_valid_o ? 16'h0000 : 16'hFFFF;
    assign pt_z_o = pt_valid_o ? 16'h4000 - 16'h000A * cnt[1:0] : ~16'h4000;
endmodule // mthc_ctrl_model
`default_nettype wire

// ==== testbench/mthc_top_tb.sv ====
// self-checking bench for the sequencing block
`default_nettype none
module mthc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] q;
    logic [31:0] res [6] = '{32'h0000_000F, 32'h0000_0000, 32'h0000_001E,
        32'h0000_001E, 32'h0000_000B, 32'h0000_0010};
    wire [31:0] rdat;
    wire wreq, sync, pv, pl, start, llow, sw, alm;
    wire [15:0] px, pz;
    int n_errors = 0;
    int n_tests = 0;
    int n_starts = 0;
    int t0;
    int s;
    mthc_top #(.CYC_PER_MS(100)) u_mthc_top (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .sync_in_i(sync), .pt_valid_i(pv),
        .pt_x_i(px), .pt_z_i(pz), .pt_last_i(pl), .meas_start_o(start),
        .laser_low_o(llow), .switch_o(sw), .alarm_o(alm));
    mthc_ctrl_model u_mthc_ctrl_model (.clk_i(sys_clk_i), .meas_start_i(start),
        .sync_o(sync), .pt_valid_o(pv), .pt_x_o(px), .pt_z_o(pz),
        .pt_last_o(pl));
    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (start === 1'b1) n_starts <= n_starts + 1;
    task chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    endtask
    task wait_start(input int lim);
        s = n_starts;
        t0 = 0;
        while (n_starts == s && t0 < lim) begin
            @(posedge sys_clk_i);
            t0++;
        end
    endtask
    task conclude();
        $display("errors %0d in %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #(40000 * 5);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        bus(0, 5'h1F, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(0, 5'h00, 32'h0);
        chk("ctrl reset", q, 32'h04);
        bus(1, 5'h02, 32'h04);
        bus(1, 5'h03, 32'h0A);
        bus(1, 5'h05, 32'h00);
        repeat (1500) @(posedge sys_clk_i);
        chk("launch while held", n_starts, 0);
        u_mthc_ctrl_model.drive(1'b0, 0);
        wait_start(3000);
        chk("release wait", t0 >= 1000, 1);
        wait_start(500);
        for (int i = 0; i < 6; i++) begin
            bus(0, 5'h0C + i[4:0], 32'h0);
            chk("result", q, res[i]);
        end
        bus(0, 5'h0B, 32'h0);
        chk("quality", q[1:0], 2'h2);
        chk("alarm", alm, 1'b0);
        chk("switch on", sw, 1'b1);
        bus(1, 5'h03, 32'h14);
        wait_start(500);
        wait_start(500);
        chk("switch off", sw, 1'b0);
        u_mthc_ctrl_model.drive(1'b1, 300);
        chk("laser low", llow, 1'b1);
        s = n_starts;
        repeat (600) @(posedge sys_clk_i);
        chk("held launches", n_starts - s, 0);
        u_mthc_ctrl_model.drive(1'b0, 0);
        wait_start(3000);
        chk("resume wait", t0 >= 1000, 1);
        bus(1, 5'h00, 32'h01);
        bus(1, 5'h01, 32'h02);
        repeat (400) @(posedge sys_clk_i);
        s = n_starts;
        repeat (2000) @(posedge sys_clk_i);
        chk("interval rate", n_starts - s inside {[9:11]}, 1);
        bus(1, 5'h00, 32'h02);
        repeat (300) @(posedge sys_clk_i);
        s = n_starts;
        repeat (3) begin
            u_mthc_ctrl_model.drive(1'b1, 50);
            u_mthc_ctrl_model.drive(1'b0, 400);
        end
        chk("single shots", n_starts - s, 3);
        bus(1, 5'h06, 32'h0000_0100);
        bus(1, 5'h08, 32'h0000_0001);
        bus(0, 5'h06, 32'h0);
        chk("tilt view", q, 32'h0000_8000);
        bus(1, 5'h0A, 32'h0000_1000);
        bus(1, 5'h08, 32'h0000_0002);
        bus(0, 5'h0A, 32'h0);
        chk("tilt dist", q, 32'h0000_4000);
        bus(0, 5'h08, 32'h0);
        chk("tilt off", q, 32'h0000_0000);
        conclude();
    end
endmodule // mthc_top_tb
`default_nettype wire
